// ### core/fse_params.svh
/*
 * Named constants for the float status and exception control block.
 * Assumes it is included by bare name from the package and the core.
 */
`ifndef FSE_PARAMS_SVH
`define FSE_PARAMS_SVH
// Status word field positions.
`define FSE_B_ERR 15
`define FSE_B_GID 14
`define FSE_B_RSV_HI 13
`define FSE_B_RSV_LO 12
`define FSE_B_UV 11
`define FSE_B_UN 10
`define FSE_B_OV 9
`define FSE_B_CV 8
`define FSE_B_DBL 7
`define FSE_B_LONG 6
`define FSE_B_CHOP 5
`define FSE_B_MAINT 4
`define FSE_B_NEG 3
`define FSE_B_ZERO 2
`define FSE_B_VOVF 1
`define FSE_B_CARRY 0
// Exception codes.
`define FSE_EC_NONE 4'h0
`define FSE_EC_OPCODE 4'h2
`define FSE_EC_DIVZ 4'h4
`define FSE_EC_CONV 4'h6
`define FSE_EC_OVF 4'h8
`define FSE_EC_UNF 4'ha
`define FSE_EC_UNDEF 4'hc
`define FSE_EC_MAINT 4'he
// Widths, limits and reset values.
`define FSE_W_EXP 10
`define FSE_W_FRAC 55
`define FSE_W_SGL_LOW 32
`define FSE_INT_SHORT 6'h10
`define FSE_INT_LONG 6'h20
`define FSE_MODE_AC 3'h0
`define FSE_ST_RESET 16'h0000
`define FSE_ADDR_RESET 16'h0000
`endif

// ### core/fse_pkg.sv
/*
 * Types shared by the float status and exception control block.
 * Assumes the constants header sits beside it.
 */
`include "fse_params.svh"
package fse_pkg;
  typedef logic [15:0] fse_word_t;
  typedef logic [3:0] fse_code_t;
  typedef logic [`FSE_W_EXP-1:0] fse_exp_t;
  typedef logic [`FSE_W_FRAC-1:0] fse_frac_t;
endpackage : fse_pkg

// ### core/fse_ctrl.sv
/*
 * Float status word, mode control and exception decision logic.
 * Assumes the instruction sequencer presents one finished operation per
 * op_valid pulse, on the same clock, with its raw result and event flags.
 */
`timescale 1ns/10ps
`include "fse_params.svh"
module fse_ctrl import fse_pkg::*; #(
  parameter bit MAINT_IMPL = 1'b1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Status load from the instruction stream.
  input wire logic load_status_instr,
  input wire fse_word_t load_status_data,
  input wire logic kernel_mode,
  // Finished operation.
  input wire logic op_valid,
  input wire logic [15:0] op_addr,
  input wire logic [2:0] op_src_mode,
  input wire logic op_uv_class,
  input wire logic op_uv_after,
  input wire logic op_minus_zero,
  input wire logic op_illegal,
  input wire logic op_div_zero,
  input wire logic op_maint_trap,
  input wire logic op_exp_overflow,
  input wire logic op_exp_underflow,
  input wire logic raw_sign,
  input wire fse_exp_t raw_exp,
  input wire fse_frac_t raw_frac,
  input wire logic raw_round_bit,
  // Conversion to integer.
  input wire logic op_convert,
  input wire logic [5:0] conv_bits_needed,
  input wire logic [31:0] conv_value,
  input wire logic conv_carry,
  // Status and exception registers.
  output fse_word_t float_status_word,
  output fse_code_t exception_code_reg,
  output logic [15:0] exception_address_reg,
  // Modes for the datapath.
  output logic double_precision_mode,
  output logic long_integer_mode,
  output logic chop_mode,
  output logic maintenance_mode,
  // Result and interrupt.
  output logic res_store,
  output logic res_sign,
  output logic [7:0] res_exp,
  output fse_frac_t res_frac,
  output logic int_store,
  output logic [31:0] int_result,
  output logic irq,
  output logic irq_before_exec
);

  // Status fields.
  logic err_q, gid_q, uv_en_q, un_en_q, ov_en_q, cv_en_q;
  logic dbl_q, long_q, chop_q, maint_q;
  logic neg_q, zero_q, vovf_q, carry_q;
  fse_code_t code_q;
  logic [15:0] addr_q;
  logic store_q, sign_q, istore_q, irq_q, before_q;
  logic [7:0] exp_q;
  fse_frac_t frac_q;
  logic [31:0] int_q;

  // Exception decision, all from the current operation.
  logic mem_opnd, uv_hit, uv_before, conv_fail, ov_hit, un_hit;
  logic cv_hit, mt_hit, hard_hit, exc_taken, abort;
  fse_code_t exc_code;
  assign mem_opnd = op_src_mode != `FSE_MODE_AC;
  assign uv_hit = op_valid & uv_en_q & op_uv_class & mem_opnd &
                  op_minus_zero;
  assign uv_before = uv_hit & ~op_uv_after;
  assign conv_fail = op_valid & op_convert &
    (conv_bits_needed > (long_q ? `FSE_INT_LONG : `FSE_INT_SHORT));
  assign ov_hit = op_valid & op_exp_overflow & ov_en_q;
  assign un_hit = op_valid & op_exp_underflow & un_en_q;
  assign cv_hit = conv_fail & cv_en_q;
  assign mt_hit = op_valid & op_maint_trap & maint_q;
  assign hard_hit = op_valid & (op_illegal | op_div_zero);
  assign exc_taken = hard_hit | uv_hit | ov_hit | un_hit | cv_hit | mt_hit;
  assign abort = op_valid & (op_illegal | op_div_zero | uv_before);

  // Priority follows the order in which the faults arise in execution.
  always_comb begin
    if (op_valid & op_illegal) begin
      exc_code = `FSE_EC_OPCODE;
    end else if (uv_before) begin
      exc_code = `FSE_EC_UNDEF;
    end else if (op_valid & op_div_zero) begin
      exc_code = `FSE_EC_DIVZ;
    end else if (cv_hit) begin
      exc_code = `FSE_EC_CONV;
    end else if (ov_hit) begin
      exc_code = `FSE_EC_OVF;
    end else if (un_hit) begin
      exc_code = `FSE_EC_UNF;
    end else if (uv_hit) begin
      exc_code = `FSE_EC_UNDEF;
    end else if (mt_hit) begin
      exc_code = `FSE_EC_MAINT;
    end else begin
      exc_code = `FSE_EC_NONE;
    end
  end

  // Rounding adds one at the guard position; a carry may bump the exponent.
  logic [`FSE_W_EXP+`FSE_W_FRAC-1:0] rnd_sum;
  fse_frac_t frac_m;
  logic st_sign, st_zero_force, st_zero;
  logic [7:0] st_exp;
  fse_frac_t st_frac;
  assign rnd_sum = {raw_exp, raw_frac} +
    {{(`FSE_W_EXP+`FSE_W_FRAC-1){1'b0}}, ~chop_q & raw_round_bit};
  // Single precision keeps only the upper fraction bits.
  assign frac_m = dbl_q ? rnd_sum[`FSE_W_FRAC-1:0] :
    {rnd_sum[`FSE_W_FRAC-1:`FSE_W_SGL_LOW],
     {`FSE_W_SGL_LOW{1'b0}}};
  assign st_zero_force = (op_exp_overflow & ~ov_en_q) |
                         (op_exp_underflow & ~un_en_q);
  assign st_exp = st_zero_force ? 8'h00 :
    rnd_sum[`FSE_W_FRAC+7:`FSE_W_FRAC];
  // A minus zero pattern without a trap becomes a clean zero.
  assign st_sign = ~st_zero_force & raw_sign &
                   ~((st_exp == 8'h00) & ~exc_taken);
  assign st_frac = (st_zero_force | ((st_exp == 8'h00) & ~exc_taken)) ?
    '0 : frac_m;
  assign st_zero = st_exp == 8'h00;

  logic [31:0] int_val;
  assign int_val = conv_fail ? 32'h0000_0000 :
    (long_q ? conv_value :
     {{16{conv_value[15]}}, conv_value[15:0]});

  // Sticky error flag: set wins over a simultaneous load.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_q <= 1'b0;
    end else if (exc_taken) begin
      err_q <= 1'b1;
    end else if (load_status_instr) begin
      err_q <= load_status_data[`FSE_B_ERR];
    end
  end

  // Mode and enable bits, written only by a status load.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gid_q <= 1'b0;
      uv_en_q <= 1'b0;
      un_en_q <= 1'b0;
      ov_en_q <= 1'b0;
      cv_en_q <= 1'b0;
      dbl_q <= 1'b0;
      long_q <= 1'b0;
      chop_q <= 1'b0;
    end else if (load_status_instr) begin
      gid_q <= load_status_data[`FSE_B_GID];
      uv_en_q <= load_status_data[`FSE_B_UV];
      un_en_q <= load_status_data[`FSE_B_UN];
      ov_en_q <= load_status_data[`FSE_B_OV];
      cv_en_q <= load_status_data[`FSE_B_CV];
      dbl_q <= load_status_data[`FSE_B_DBL];
      long_q <= load_status_data[`FSE_B_LONG];
      chop_q <= load_status_data[`FSE_B_CHOP];
    end
  end

  // Maintenance bit; outside kernel mode a load leaves it alone.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      maint_q <= 1'b0;
    end else if (load_status_instr & kernel_mode & MAINT_IMPL) begin
      maint_q <= load_status_data[`FSE_B_MAINT];
    end
  end

  // Condition codes; an aborted operation leaves them as they were.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      neg_q <= 1'b0;
      zero_q <= 1'b0;
      vovf_q <= 1'b0;
      carry_q <= 1'b0;
    end else if (op_valid & ~abort) begin
      neg_q <= op_convert ? int_val[31] : st_sign;
      zero_q <= op_convert ? (int_val == 32'h0000_0000) : st_zero;
      vovf_q <= op_exp_overflow;
      carry_q <= op_convert & conv_carry;
    end else if (load_status_instr) begin
      neg_q <= load_status_data[`FSE_B_NEG];
      zero_q <= load_status_data[`FSE_B_ZERO];
      vovf_q <= load_status_data[`FSE_B_VOVF];
      carry_q <= load_status_data[`FSE_B_CARRY];
    end
  end

  // Exception code and address hold until the next taken exception.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code_q <= `FSE_EC_NONE;
      addr_q <= `FSE_ADDR_RESET;
    end else if (exc_taken) begin
      code_q <= exc_code;
      addr_q <= op_addr;
    end
  end

  // Result strobes and interrupt, one cycle after the operation.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      store_q <= 1'b0;
      sign_q <= 1'b0;
      exp_q <= 8'h00;
      frac_q <= '0;
      istore_q <= 1'b0;
      int_q <= 32'h0000_0000;
      irq_q <= 1'b0;
      before_q <= 1'b0;
    end else begin
      store_q <= op_valid & ~abort & ~op_convert;
      sign_q <= st_sign;
      exp_q <= st_exp;
      frac_q <= st_frac;
      istore_q <= op_valid & ~abort & op_convert;
      int_q <= int_val;
      irq_q <= exc_taken & ~gid_q;
      before_q <= exc_taken & ~gid_q & abort;
    end
  end

  // Reserved bits read back as zero.
  assign float_status_word = {err_q, gid_q, 2'b00, uv_en_q, un_en_q,
    ov_en_q, cv_en_q, dbl_q, long_q, chop_q, maint_q,
    neg_q, zero_q, vovf_q, carry_q};
  assign exception_code_reg = code_q;
  assign exception_address_reg = addr_q;
  assign double_precision_mode = dbl_q;
  assign long_integer_mode = long_q;
  assign chop_mode = chop_q;
  assign maintenance_mode = maint_q;
  assign res_store = store_q;
  assign res_sign = sign_q;
  assign res_exp = exp_q;
  assign res_frac = frac_q;
  assign int_store = istore_q;
  assign int_result = int_q;
  assign irq = irq_q;
  assign irq_before_exec = before_q;

  // Checks on the exception and status behaviour.
  a_err_sets: assert property (@(posedge clk) disable iff (!rst_n)
    exc_taken |=> err_q) else $error("error flag not set");
  a_err_holds: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(err_q) |-> $past(load_status_instr))
    else $error("error flag cleared without load");
  a_gid_mutes: assert property (@(posedge clk) disable iff (!rst_n)
    gid_q & exc_taken |=> !irq_q) else $error("irq despite disable");
  a_rsv_zero: assert property (@(posedge clk) disable iff (!rst_n)
    float_status_word[13:12] == 2'b00)
    else $error("reserved bits nonzero");
  a_uv_ac_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    op_valid & (op_src_mode == 3'h0) & op_minus_zero & !op_illegal &
    !op_div_zero & !op_exp_overflow & !op_exp_underflow & !op_maint_trap &
    !op_convert |=> !irq_q) else $error("accumulator minus zero trap");
  a_uv_traps: assert property (@(posedge clk) disable iff (!rst_n)
    op_valid & uv_en_q & !gid_q & op_uv_class & (op_src_mode != 3'h0) &
    op_minus_zero & !op_uv_after |=> irq_q & before_q & !store_q)
    else $error("undefined variable not trapped");
  a_no_mzero: assert property (@(posedge clk) disable iff (!rst_n)
    store_q & sign_q & (exp_q == 8'h00) |-> irq_q | gid_q | $past(gid_q))
    else $error("minus zero stored silently");
  a_ovf_zero: assert property (@(posedge clk) disable iff (!rst_n)
    op_valid & op_exp_overflow & !ov_en_q & !abort & !op_convert
    |=> store_q & (exp_q == 8'h00) & (frac_q == '0) & !sign_q)
    else $error("disabled overflow not zero");
  a_unf_zero: assert property (@(posedge clk) disable iff (!rst_n)
    op_valid & op_exp_underflow & !un_en_q & !abort & !op_convert
    |=> store_q & (exp_q == 8'h00) & (frac_q == '0))
    else $error("disabled underflow not zero");
  a_conv_zero: assert property (@(posedge clk) disable iff (!rst_n)
    conv_fail & !abort |=> istore_q & (int_q == 32'h0000_0000) &
    (irq_q == ($past(cv_en_q) & !$past(gid_q))))
    else $error("failed conversion result");
  a_code_stable: assert property (@(posedge clk) disable iff (!rst_n)
    !exc_taken |=> $stable(code_q) && $stable(addr_q))
    else $error("exception code moved");
  a_maint_user: assert property (@(posedge clk) disable iff (!rst_n)
    load_status_instr & !kernel_mode |=> $stable(maint_q))
    else $error("maintenance set outside kernel");
  c_taken_irq: cover property (@(posedge clk) disable iff (!rst_n)
    exc_taken ##1 irq_q);
  c_div_zero: cover property (@(posedge clk) disable iff (!rst_n)
    op_valid & op_div_zero & gid_q);
  c_load_clear: cover property (@(posedge clk) disable iff (!rst_n)
    err_q ##1 load_status_instr ##1 !err_q);
  c_conv_fail: cover property (@(posedge clk) disable iff (!rst_n)
    conv_fail & long_q);

endmodule : fse_ctrl

// ### testbench/fse_host.sv
/* Host sequencer model that issues status loads and finished operations.
   Assumes the bench calls its tasks and shares the block's clock. */
`timescale 1ns/10ps
module fse_host import fse_pkg::*; (
  // Clock.
  input wire logic clk,
  // Requests towards the block.
  output logic ld,
  output fse_word_t ld_d,
  output logic kern,
  output logic vld,
  output logic [15:0] addr,
  output logic [2:0] mode,
  output logic [9:0] ev,
  output logic [9:0] ex,
  output logic [5:0] nb,
  output logic [31:0] cv
);
  // Start idle, so nothing is requested before reset is released.
  initial begin
    ld = 1'b0;
    ld_d = '0;
    kern = 1'b0;
    vld = 1'b0;
    addr = '0;
    mode = '0;
    ev = '0;
    ex = '0;
    nb = '0;
    cv = '0;
  end

  // A load is held for exactly one sampling edge.
  task automatic load(input fse_word_t d, input logic k);
    @(negedge clk);
    ld <= 1'b1;
    ld_d <= d;
    kern <= k;
    @(negedge clk);
    ld <= 1'b0;
    ld_d <= ~d; // Stale data is inverted so nothing can lean on it.
  endtask : load

  // An operation is one pulse; events drop with it.
  task automatic op(input logic [9:0] e, input logic [2:0] m,
      input logic [9:0] x, input logic [5:0] n, input logic [31:0] c,
      input logic [15:0] a);
    @(negedge clk);
    vld <= 1'b1;
    ev <= e;
    mode <= m;
    ex <= x;
    nb <= n;
    cv <= c;
    addr <= a;
    @(negedge clk);
    vld <= 1'b0;
    ev <= '0;
    cv <= ~c;
    addr <= ~a;
  endtask : op
endmodule : fse_host

// ### testbench/tb_fse_ctrl.sv
/* Self-checking bench for the float status and exception block.
   Assumes the host model and the package are compiled before it. */
`timescale 1ns/10ps
module tb_fse_ctrl import fse_pkg::*; ();
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ld, kern, vld, seen_q;
  fse_word_t ld_d, s, st;
  fse_code_t ec, code;
  logic [15:0] ea, a, ea_o, addr;
  logic [2:0] mode;
  logic [9:0] ev, ex;
  logic [5:0] nb;
  logic [31:0] cv, ires;
  logic dbl, lng, chp, mnt, rs, r_sign, is, irq;
  logic [7:0] r_exp;
  fse_frac_t r_frac;
  logic [70:0] q[$];
  logic [70:0] note;
  logic rsg = 1'b0;
  logic rnd = 1'b0;
  logic ibe;
  fse_frac_t rfr = '0;
  int n_mismatch = 0;
  int checks = 0;

  always #5 clk = ~clk;

  fse_host host (.clk(clk), .ld(ld), .ld_d(ld_d), .kern(kern), .vld(vld),
    .addr(addr), .mode(mode), .ev(ev), .ex(ex), .nb(nb), .cv(cv));

  fse_ctrl dut (.clk(clk), .rst_n(rst_n), .load_status_instr(ld),
    .load_status_data(ld_d), .kernel_mode(kern), .op_valid(vld),
    .op_addr(addr), .op_src_mode(mode), .op_uv_class(ev[9]),
    .op_uv_after(ev[8]), .op_minus_zero(ev[7]), .op_illegal(ev[6]),
    .op_div_zero(ev[5]), .op_maint_trap(ev[4]), .op_exp_overflow(ev[3]),
    .op_exp_underflow(ev[2]), .raw_sign(rsg), .raw_exp(ex),
    .raw_frac(rfr), .raw_round_bit(rnd), .op_convert(ev[1]),
    .conv_bits_needed(nb), .conv_value(cv), .conv_carry(ev[0]),
    .float_status_word(st), .exception_code_reg(code),
    .exception_address_reg(ea_o), .double_precision_mode(dbl),
    .long_integer_mode(lng), .chop_mode(chp), .maintenance_mode(mnt),
    .res_store(rs), .res_sign(r_sign), .res_exp(r_exp), .res_frac(r_frac),
    .int_store(is), .int_result(ires), .irq(irq), .irq_before_exec(ibe));

  task automatic chk(input string nm, input logic [70:0] got, exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic stop_test();
    if (n_mismatch == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  // Loads copy the word; reserved bits read zero, and outside kernel mode
  // the maintenance bit keeps whatever value it had.
  task automatic t_ld(input fse_word_t d, input logic k);
    s = (d & 16'hcfef) | ((k ? d : s) & 16'h0010);
    q.push_back({s, ec, ea, 3'b000, 32'h0});
    host.load(d, k);
  endtask : t_ld

  // Notes the expected outcome of one operation, then issues it.
  task automatic t_op(input logic [9:0] e, input logic [2:0] m,
      input logic [9:0] x, input logic [5:0] n, input logic [31:0] c,
      input logic tk, input fse_code_t k, input logic [3:0] cc,
      input logic [1:0] sto, input logic [31:0] d);
    a = 16'($urandom);
    if (tk) begin
      ec = k;
      ea = a;
    end
    s = {s[15] | tk, s[14:4], cc};
    q.push_back({s, ec, ea, tk & ~s[14], sto, d});
    host.op(e, m, x, n, c, a);
  endtask : t_op

  // A result shows one cycle after each request is taken.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= ld | vld;
    end
  end

  // Compare the oldest note once the answer has settled.
  always @(negedge clk) begin
    if (seen_q) begin
      note = q.pop_front();
      chk("result", {st, code, ea_o, irq, rs, is, rs ? {r_sign, r_exp,
        r_frac[54:32]} : (is ? ires : 32'h0)}, note);
      chk("modes", 71'({dbl, lng, chp, mnt}), 71'(note[62:59]));
      // Only an operation that stores nothing was cut short before it ran.
      chk("before", 71'(ibe), 71'(note[34] & ~note[33] & ~note[32]));
    end
  end

  // A hang is cut short here and counted.
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end

  initial begin
    void'($urandom(68));
    ec = '0;
    ea = '0;
    s = '0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    chk("reset", 71'({st, code, ea_o, irq, rs, is}), 71'h0);
    t_op(10'h020, 3'h1, 10'h0, 6'h0, 0, 1, 4'h4, 4'h0, 2'b00, 0);
    t_ld(16'h4000, 1'b0);
    t_op(10'h020, 3'h1, 10'h0, 6'h0, 0, 1, 4'h4, 4'h0, 2'b00, 0);
    t_op(10'h040, 3'h1, 10'h0, 6'h0, 0, 1, 4'h2, 4'h0, 2'b00, 0);
    // An all-ones fraction with the round bit set carries into the exponent.
    rnd = 1'b1;
    rfr = '1;
    t_op(10'h000, 3'h1, 10'h081, 6'h0, 0, 0, 0, 4'h0, 2'b10,
      32'h4100_0000);
    t_ld(16'h0020, 1'b0);
    t_op(10'h000, 3'h1, 10'h081, 6'h0, 0, 0, 0, 4'h0, 2'b10,
      32'h40ff_ffff);
    rnd = 1'b0;
    rfr = '0;
    t_ld(16'h0000, 1'b0);
    t_op(10'h008, 3'h1, 10'h1ab, 6'h0, 0, 0, 0, 4'h6, 2'b10, 0);
    t_ld(16'h0600, 1'b0);
    t_op(10'h008, 3'h1, 10'h1ab, 6'h0, 0, 1, 4'h8, 4'h2, 2'b10,
      32'h5580_0000);
    t_op(10'h004, 3'h1, 10'h3c5, 6'h0, 0, 1, 4'ha, 4'h0, 2'b10,
      32'h6280_0000);
    t_ld(16'h0000, 1'b0);
    t_op(10'h004, 3'h1, 10'h3c5, 6'h0, 0, 0, 0, 4'h4, 2'b10, 0);
    t_op(10'h002, 3'h1, 10'h0, 6'h11, 1, 0, 0, 4'h4, 2'b01, 0);
    t_op(10'h003, 3'h1, 10'h0, 6'h10, 32'h8001, 0, 0, 4'h9, 2'b01,
      32'hffff_8001);
    t_ld(16'h0140, 1'b0);
    t_op(10'h002, 3'h1, 10'h0, 6'h21, 1, 1, 4'h6, 4'h4, 2'b01, 0);
    t_op(10'h002, 3'h1, 10'h0, 6'h20, 32'h1234_5678, 0, 0, 4'h0, 2'b01,
      32'h1234_5678);
    t_ld(16'h0800, 1'b0);
    t_op(10'h280, 3'h1, 10'h0, 6'h0, 0, 1, 4'hc, 4'h0, 2'b00, 0);
    t_op(10'h380, 3'h1, 10'h0, 6'h0, 0, 1, 4'hc, 4'h4, 2'b10, 0);
    // A minus zero result pattern without a trap must come out clean.
    rsg = 1'b1;
    t_op(10'h280, 3'h0, 10'h0, 6'h0, 0, 0, 0, 4'h4, 2'b10, 0);
    rsg = 1'b0;
    t_ld(16'h0010, 1'b0);
    t_ld(16'h0010, 1'b1);
    t_op(10'h010, 3'h1, 10'h0, 6'h0, 0, 1, 4'he, 4'h4, 2'b10, 0);
    for (int i = 0; i < 6; i++) begin
      t_ld(16'($urandom), 1'($urandom));
    end
    repeat (3) @(negedge clk);
    chk("drain", 71'(q.size()), 71'h0);
    stop_test();
  end
endmodule : tb_fse_ctrl
